// file: bench/fms_monitor_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fms_monitor_chk import fms_pkg::*; (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic backup_resetn,
  input wire logic startup_check,
  input wire logic engine_restart,
  input wire logic control_active,
  input wire fms_speed_s speed,
  input wire fms_faults_s faults,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic warn_lamp,
  input wire logic shutdown,
  input wire logic pattern_out,
  input wire logic [N_ACT-1:0] actuator_drive,
  input wire logic control_inhibit
);
  logic moving;
  logic fast;
  assign moving = |speed.wheel;
  assign fast = (speed.wheel[0] > SPD_TEST_MAX_KMH) || (speed.wheel[1] > SPD_TEST_MAX_KMH) ||
                (speed.wheel[2] > SPD_TEST_MAX_KMH) || (speed.wheel[3] > SPD_TEST_MAX_KMH);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  rd_moving_a: assert property (reg_rd && moving |=> reg_rdata == '0)
    else $error("read answered while wheels turn");
  shut_hold_a: assert property (shutdown |=> shutdown)
    else $error("shutdown dropped without reset");
  test_lamp_a: assert property (control_inhibit |-> warn_lamp)
    else $error("lamp dark during actuator test");
  drive_one_a: assert property (actuator_drive != '0 |-> control_inhibit && $onehot(actuator_drive))
    else $error("actuator drive not one-hot inside a test");
  test_abort_a: assert property (control_inhibit && fast |-> ##[1:3] !control_inhibit)
    else $error("test not aborted above speed limit");
  int_shut_a: assert property (faults.internal |-> ##[1:2] shutdown)
    else $error("internal failure did not shut down");
  decel_shut_a: assert property (faults.decel && !startup_check |-> ##[1:2] shutdown)
    else $error("decel fault in operation did not shut down");
  open_lamp_a: assert property ((|faults.sens_open) |=> warn_lamp)
    else $error("open sensor did not light lamp");
  cover property (control_inhibit && fast);
  cover property ($rose(shutdown));
  cover property ($past(reg_rd) && reg_rdata != '0);
endmodule // fms_monitor_chk
bind fms_monitor fms_monitor_chk u_fms_monitor_chk (.mclk(mclk), .resetn(resetn),
  .backup_resetn(backup_resetn), .startup_check(startup_check), .engine_restart(engine_restart),
  .control_active(control_active), .speed(speed), .faults(faults), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .warn_lamp(warn_lamp),
  .shutdown(shutdown), .pattern_out(pattern_out), .actuator_drive(actuator_drive),
  .control_inhibit(control_inhibit));
`default_nettype wire

// file: bench/fms_tool.sv
`timescale 1ns/1ps
`default_nettype none
module fms_tool import fms_pkg::*; (
  input wire logic mclk,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  // the item number rides in bits 7:4 beside the start bit
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge mclk);
    q = reg_rdata;
    @(posedge mclk);
  endtask
endmodule // fms_tool
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import fms_pkg::*; ;
  localparam int TK = 4;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic backup_resetn = 1'b0;
  logic startup_check = 1'b0;
  logic engine_restart = 1'b0;
  logic control_active = 1'b0;
  fms_speed_s speed = '0;
  fms_faults_s faults = '0;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, q;
  logic reg_wr, reg_rd, warn_lamp, shutdown, pattern_out, control_inhibit;
  logic [N_ACT-1:0] actuator_drive;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  always #25 mclk = ~mclk;
  fms_monitor #(.TICK_CYCLES(TK), .SHUT_DELAY_TICKS(5), .STOP_CONFIRM_TICKS(8)) u_fms_monitor (
    .mclk(mclk), .resetn(resetn), .backup_resetn(backup_resetn), .startup_check(startup_check),
    .engine_restart(engine_restart), .control_active(control_active), .speed(speed), .faults(faults),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .warn_lamp(warn_lamp), .shutdown(shutdown), .pattern_out(pattern_out),
    .actuator_drive(actuator_drive), .control_inhibit(control_inhibit));
  fms_tool u_fms_tool (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic wr(input logic [31:0] d);
    u_fms_tool.wr(REG_CMD, d);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    u_fms_tool.rd(a, q);
  endtask
  // reads status and compares the stored code count
  task automatic stc(input logic [3:0] e);
    rd(REG_STATUS);
    ck(32'(q[11:8]), 32'(e));
  endtask
  task automatic spd(input logic [SPD_W-1:0] v);
    speed.wheel <= {4{v}};
  endtask
  task automatic rst();
    resetn <= 1'b0;
    w(8);
    resetn <= 1'b1;
    w(1);
  endtask
  // cycles between two pattern edges
  task automatic gap();
    logic p;
    for (int k = 0; k < 2; k++) begin
      p = pattern_out;
      n = 0;
      while (pattern_out === p && n < 5000) begin
        @(negedge mclk);
        n++;
      end
    end
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    w(8);
    backup_resetn <= 1'b1;
    resetn <= 1'b1;
    w(1);
    stc(4'h0);
    rd(REG_CODE);
    ck(q, 32'h0);
    rd(8'h10);
    ck(q, 32'h0);
    gap();
    ck(32'(n), 32'(BLINK_MS * TK));
    for (int i = 0; i < N_ACT; i++) begin
      wr(32'(i * 16 + 2));
      w(2);
      @(negedge mclk);
      ck(32'(actuator_drive), 32'(1 << i));
      ck(32'({control_inhibit, warn_lamp}), 32'h3);
      rd(REG_TEST);
      ck(q, 32'(i));
      wr(32'h4);
      w(2);
      @(negedge mclk);
      ck(32'(actuator_drive), 32'h0);
    end
    wr(32'h82);
    w(2);
    @(negedge mclk);
    ck(32'(actuator_drive), 32'h0);
    stc(4'h0);
    ck(32'(q[4]), 32'h1);
    wr(32'h32);
    spd(8'h0A);
    w(3);
    @(negedge mclk);
    ck(32'(actuator_drive), 32'h8);
    w(1);
    spd(8'h0B);
    w(3);
    @(negedge mclk);
    ck(32'(control_inhibit), 32'h0);
    rd(REG_STATUS);
    ck(q, 32'h0);
    spd(8'h00);
    stc(4'h0);
    ck(32'(q[3]), 32'h1);
    faults.stoplight <= 1'b1;
    w(20);
    stc(4'h0);
    w(40);
    stc(4'h1);
    ck(32'(q[1:0]), 32'h1);
    w(20);
    stc(4'h1);
    rd(REG_CODE);
    ck(q, 32'h22);
    faults.stoplight <= 1'b0;
    wr(32'h1);
    stc(4'h0);
    rd(REG_CODE);
    ck(q, 32'h0);
    startup_check <= 1'b1;
    faults.decel <= 1'b1;
    w(6);
    stc(4'h0);
    ck(32'(q[1]), 32'h0);
    faults.internal <= 1'b1;
    w(3);
    stc(4'h1);
    ck(32'(q[1]), 32'h1);
    wr(32'h1);
    stc(4'h1);
    ck(32'(q[5]), 32'h1);
    wr(32'h12);
    stc(4'h1);
    ck(32'(q[4:2]), 32'h4);
    faults.internal <= 1'b0;
    startup_check <= 1'b0;
    w(3);
    stc(4'h2);
    faults.decel <= 1'b0;
    rd(REG_CODE);
    ck(q, 32'h21);
    rd(REG_CODE);
    ck(q, 32'h55);
    rd(REG_CODE);
    ck(q, 32'h0);
    rst();
    stc(4'h2);
    rd(REG_CODE);
    ck(q, 32'h21);
    faults.sens_open[1] <= 1'b1;
    w(2);
    @(negedge mclk);
    ck(32'(warn_lamp), 32'h1);
    w(8);
    stc(4'h2);
    spd(8'h07);
    w(10);
    // the tool is refused while wheels turn, so stop them before reading
    spd(8'h00);
    stc(4'h3);
    ck(32'(q[1]), 32'h0);
    w(20);
    stc(4'h3);
    ck(32'(q[1]), 32'h1);
    faults.sens_open <= '0;
    rst();
    engine_restart <= 1'b1;
    control_active <= 1'b1;
    faults.sens_short[0] <= 1'b1;
    w(4);
    stc(4'h3);
    spd(8'h19);
    w(6);
    @(negedge mclk);
    ck(32'(shutdown), 32'h0);
    w(1);
    // still well inside the delayed window, so only the speed path can shut down
    control_active <= 1'b0;
    w(3);
    @(negedge mclk);
    ck(32'(shutdown), 32'h1);
    w(1);
    spd(8'h00);
    faults.sens_short <= '0;
    stc(4'h4);
    ck(32'(q[1]), 32'h1);
    rst();
    faults.motor <= 1'b1;
    w(4);
    @(negedge mclk);
    ck(32'(shutdown), 32'h0);
    w(1);
    spd(SPD_SENSE_KMH);
    w(3);
    @(negedge mclk);
    ck(32'(shutdown), 32'h1);
    conclude();
  end
endmodule // tb
`default_nettype wire

// file: common/fms_pkg.sv
package fms_pkg;
  // clock and tick base
  localparam int CLK_NS = 50;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int DIV_W = 15;
  // times, each in its own unit
  localparam int SHUT_DELAY_S = 60;
  localparam int SHUT_DELAY_MS = SHUT_DELAY_S * 1000;
  localparam int STOP_CONFIRM_MIN = 15;
  localparam int STOP_CONFIRM_MS = STOP_CONFIRM_MIN * 60 * 1000;
  localparam int BLINK_MS = 500;
  localparam int DIGIT_GAP_MS = 1500;
  localparam int CODE_GAP_MS = 3000;
  localparam int MS_W = 20;
  // speed thresholds in km/h
  localparam int SPD_W = 8;
  localparam logic [SPD_W-1:0] SPD_SENSE_KMH = 8'h06;
  localparam logic [SPD_W-1:0] SPD_FIRST_KMH = 8'h0A;
  localparam logic [SPD_W-1:0] SPD_RESTART_KMH = 8'h14;
  localparam logic [SPD_W-1:0] SPD_TEST_MAX_KMH = 8'h0A;
  // trouble codes, index 0 is code 11
  localparam int NCODES = 13;
  localparam logic [NCODES-1:0][7:0] CODE_TAB = {8'h55, 8'h53, 8'h51, 8'h43, 8'h42, 8'h41, 8'h22,
                                                 8'h21, 8'h15, 8'h14, 8'h13, 8'h12, 8'h11};
  localparam int IX_ABNORMAL = 4;
  localparam int IX_DECEL = 5;
  localparam int IX_STOPLIGHT = 6;
  localparam int IX_VALVE_FL = 7;
  localparam int IX_VALVE_FR = 8;
  localparam int IX_REAR = 9;
  localparam int IX_RELAY = 10;
  localparam int IX_MOTOR = 11;
  localparam int IX_INTERNAL = 12;
  localparam int MEM_AW = 4;
  localparam int MEM_DEPTH = 16;
  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CODE = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TEST = 8'h0C;
  localparam int CMD_CLEAR = 0;
  localparam int CMD_TEST = 1;
  localparam int CMD_STOP = 2;
  localparam int CMD_REWIND = 3;
  localparam int CMD_ITEM_LSB = 4;
  localparam int ITEM_W = 4;
  localparam int N_ACT = 8;
  localparam int ST_COUNT_LSB = 8;

  typedef struct packed {
    logic [3:0] sens_open;
    logic [3:0] sens_short;
    logic sens_abnormal;
    logic decel;
    logic stoplight;
    logic valve_fl;
    logic valve_fr;
    logic rear_mismatch;
    logic valve_relay;
    logic motor;
    logic internal;
  } fms_faults_s;

  typedef struct packed {
    logic [3:0][SPD_W-1:0] wheel;
  } fms_speed_s;

  typedef enum logic [2:0] {PAT_START, PAT_BLINK, PAT_READ, PAT_FETCH, PAT_DIGIT, PAT_SPACE} fms_pat_e;
endpackage

// file: rtl/fms_code_mem.sv
`timescale 1ns/1ps
`default_nettype none
module fms_code_mem import fms_pkg::*; (
  input wire logic mclk,
  input wire logic backup_resetn,
  input wire logic we,
  input wire logic [MEM_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [MEM_AW-1:0] raddr_a,
  output logic [7:0] q_a,
  input wire logic [MEM_AW-1:0] raddr_b,
  output logic [7:0] q_b
);
  logic [7:0] mem [MEM_DEPTH];

  // contents sit on the backup supply and are never reset
  always_ff @(posedge mclk) begin
    if (we) mem[waddr] <= wdata;
  end

  // write-first on both ports so a just-stored code reads back at once
  always_ff @(posedge mclk or negedge backup_resetn) begin
    if (!backup_resetn) begin
      q_a <= 8'h00;
      q_b <= 8'h00;
    end else begin
      q_a <= (we && waddr == raddr_a) ? wdata : mem[raddr_a];
      q_b <= (we && waddr == raddr_b) ? wdata : mem[raddr_b];
    end
  end
endmodule // fms_code_mem
`default_nettype wire

// file: rtl/fms_monitor.sv
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module fms_monitor import fms_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int SHUT_DELAY_TICKS = SHUT_DELAY_MS,
  parameter int STOP_CONFIRM_TICKS = STOP_CONFIRM_MS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic backup_resetn,
  input wire logic startup_check,
  input wire logic engine_restart,
  input wire logic control_active,
  input wire fms_speed_s speed,
  input wire fms_faults_s faults,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic warn_lamp,
  output logic shutdown,
  output logic pattern_out,
  output logic [N_ACT-1:0] actuator_drive,
  output logic control_inhibit
);
  logic [DIV_W-1:0] div_cnt;
  logic tick;
  logic [SPD_W-1:0] vmax;
  logic spd_zero, at6, fast, over_test;
  logic reached6, first6;
  logic [3:0] open_seen, short_seen;
  logic abnormal_seen, motor_bad, stop_seen, stop_done;
  logic sens_req, delay_done, sens_go;
  logic [NCODES-1:0] ev, stored, pend;
  logic hard_fail;
  logic [3:0] count;
  logic store_we;
  logic [3:0] store_ix;
  logic comm_ok, wr_cmd, rd_any, rd_code, do_clear;
  logic test_active;
  logic [ITEM_W-1:0] test_item;
  logic clear_refused, test_refused, comm_refused;
  logic rew_pend, rewind;
  logic [MEM_AW-1:0] rd_ptr, next_rd_ptr;
  logic [3:0] rd_left, next_rd_left;
  logic [7:0] q_a, q_b;
  fms_pat_e pat_st;
  logic [MS_W-1:0] pat_ms;
  logic [MEM_AW-1:0] pat_ptr;
  logic [3:0] pat_left, pulses, ones;
  logic second;

  // 1 ms enable
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (div_cnt == DIV_W'(TICK_CYCLES - 1)) begin
      div_cnt <= '0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // fastest wheel and threshold compares
  always_comb begin
    vmax = '0;
    for (int i = 0; i < 4; i++) begin
      if (speed.wheel[i] > vmax) vmax = speed.wheel[i];
    end
  end
  assign spd_zero = (vmax == '0);
  assign at6 = (vmax >= SPD_SENSE_KMH);
  assign fast = (vmax >= (engine_restart ? SPD_RESTART_KMH : SPD_FIRST_KMH));
  assign over_test = (vmax > SPD_TEST_MAX_KMH);
  assign first6 = at6 && !reached6;

  // fault capture since ignition on
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reached6 <= 1'b0;
      open_seen <= '0;
      short_seen <= '0;
      abnormal_seen <= 1'b0;
      motor_bad <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      if (at6) reached6 <= 1'b1;
      open_seen <= open_seen | faults.sens_open;
      if (at6 || reached6) begin
        short_seen <= short_seen | (startup_check ? 4'h0 : faults.sens_short);
        if (!startup_check && faults.sens_abnormal) abnormal_seen <= 1'b1;
      end
      if (first6 && faults.motor) motor_bad <= 1'b1;
      if (stop_done) stop_seen <= 1'b1;
    end
  end

  fms_ms_timer u_stop_timer (
    .mclk(mclk),
    .resetn(resetn),
    .tick(tick),
    .run(faults.stoplight && !startup_check),
    .limit(MS_W'(STOP_CONFIRM_TICKS)),
    .done(stop_done)
  );

  // detected events, one per code
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ev[i] = reached6 && (open_seen[i] || short_seen[i]);
    end
    ev[IX_ABNORMAL] = reached6 && abnormal_seen;
    ev[IX_DECEL] = !startup_check && faults.decel;
    // only a confirmed fault that is still present stores, so a clear is not undone once the stop light fault has gone
    ev[IX_STOPLIGHT] = stop_done;
    ev[IX_VALVE_FL] = !startup_check && faults.valve_fl;
    ev[IX_VALVE_FR] = !startup_check && faults.valve_fr;
    ev[IX_REAR] = !startup_check && faults.rear_mismatch;
    ev[IX_RELAY] = faults.valve_relay;
    ev[IX_MOTOR] = motor_bad;
    ev[IX_INTERNAL] = faults.internal;
  end

  assign hard_fail = ev[IX_DECEL] | ev[IX_VALVE_FL] | ev[IX_VALVE_FR] | ev[IX_REAR] |
                     ev[IX_RELAY] | ev[IX_MOTOR] | ev[IX_INTERNAL];
  assign sens_req = |ev[IX_ABNORMAL:0];

  fms_ms_timer u_shut_timer (
    .mclk(mclk),
    .resetn(resetn),
    .tick(tick),
    .run(sens_req && !shutdown),
    .limit(MS_W'(SHUT_DELAY_TICKS)),
    .done(delay_done)
  );

  assign sens_go = sens_req && !control_active && (fast || delay_done);

  // shutdown holds until the next ignition cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shutdown <= 1'b0;
    end else if (hard_fail || sens_go) begin
      shutdown <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      warn_lamp <= 1'b1;
    end else begin
      warn_lamp <= startup_check || (|faults.sens_open) || (|open_seen) || stop_seen || shutdown ||
                   hard_fail || sens_go || test_active;
    end
  end

  // code store: lowest pending index first, once per code
  always_comb begin
    pend = ev & ~stored;
    store_we = 1'b0;
    store_ix = '0;
    for (int i = NCODES - 1; i >= 0; i--) begin
      if (pend[i]) begin
        store_we = 1'b1;
        store_ix = 4'(i);
      end
    end
  end

  assign comm_ok = spd_zero;
  assign wr_cmd = reg_wr && reg_addr == REG_CMD && comm_ok;
  assign rd_any = reg_rd && comm_ok;
  assign rd_code = rd_any && reg_addr == REG_CODE;
  assign do_clear = wr_cmd && reg_wdata[CMD_CLEAR] && !faults.internal;

  // index and bitmap live in the backup domain with the memory
  always_ff @(posedge mclk or negedge backup_resetn) begin
    if (!backup_resetn) begin
      count <= '0;
      stored <= '0;
    end else if (do_clear) begin
      count <= '0;
      stored <= '0;
    end else if (store_we && !do_clear) begin
      count <= count + 1'b1;
      stored[store_ix] <= 1'b1;
    end
  end

  fms_code_mem u_mem (
    .mclk(mclk),
    .backup_resetn(backup_resetn),
    .we(store_we && !do_clear),
    .waddr(count),
    .wdata(CODE_TAB[store_ix]),
    .raddr_a(next_rd_ptr),
    .q_a(q_a),
    .raddr_b(pat_ptr),
    .q_b(q_b)
  );

  // scan read walks from the newest entry down
  assign rewind = rew_pend || store_we || do_clear || (wr_cmd && reg_wdata[CMD_REWIND]);
  always_comb begin
    next_rd_ptr = rd_ptr;
    next_rd_left = rd_left;
    if (rewind) begin
      next_rd_left = do_clear ? 4'h0 : (store_we ? count + 1'b1 : count);
      next_rd_ptr = do_clear ? '0 : (store_we ? count : count - 1'b1);
    end else if (rd_code && rd_left != 4'h0) begin
      next_rd_left = rd_left - 1'b1;
      next_rd_ptr = rd_ptr - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_ptr <= '0;
      rd_left <= '0;
      rew_pend <= 1'b1;
    end else begin
      rd_ptr <= next_rd_ptr;
      rd_left <= next_rd_left;
      rew_pend <= 1'b0;
    end
  end

  // actuator test
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      test_active <= 1'b0;
      test_item <= '0;
    end else if (test_active && (over_test || (wr_cmd && reg_wdata[CMD_STOP]))) begin
      test_active <= 1'b0;
    end else if (wr_cmd && reg_wdata[CMD_TEST] && !shutdown && spd_zero &&
                 reg_wdata[CMD_ITEM_LSB +: ITEM_W] < ITEM_W'(N_ACT)) begin
      test_active <= 1'b1;
      test_item <= reg_wdata[CMD_ITEM_LSB +: ITEM_W];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      actuator_drive <= '0;
      control_inhibit <= 1'b0;
    end else begin
      actuator_drive <= test_active ? N_ACT'(1) << test_item : '0;
      control_inhibit <= test_active;
    end
  end

  // refusal flags, set wins over the status-read clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clear_refused <= 1'b0;
      test_refused <= 1'b0;
      comm_refused <= 1'b0;
    end else begin
      if (rd_any && reg_addr == REG_STATUS) begin
        clear_refused <= 1'b0;
        test_refused <= 1'b0;
        comm_refused <= 1'b0;
      end
      if (wr_cmd && reg_wdata[CMD_CLEAR] && faults.internal) clear_refused <= 1'b1;
      if (wr_cmd && reg_wdata[CMD_TEST] && (shutdown || reg_wdata[CMD_ITEM_LSB +: ITEM_W] >= ITEM_W'(N_ACT)))
        test_refused <= 1'b1;
      if ((reg_wr || reg_rd) && !comm_ok) comm_refused <= 1'b1;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (rd_any) begin
      case (reg_addr)
        REG_STATUS: reg_rdata <= {20'h00000, count, 2'b00, clear_refused, test_refused, comm_refused,
                                  test_active, shutdown, warn_lamp};
        REG_CODE: reg_rdata <= (rd_left != 4'h0) ? {24'h000000, q_a} : '0;
        REG_TEST: reg_rdata <= {28'h0000000, test_item};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // lamp/voltmeter pattern: tens pulses, gap, ones pulses, long gap, next code
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pat_st <= PAT_START;
      pat_ms <= '0;
      pat_ptr <= '0;
      pat_left <= '0;
      pulses <= '0;
      ones <= '0;
      second <= 1'b0;
      pattern_out <= 1'b0;
    end else if (count == 4'h0 && pat_st != PAT_BLINK) begin
      pat_st <= PAT_BLINK;
      pat_ms <= '0;
      pattern_out <= 1'b0;
    end else begin
      case (pat_st)
        PAT_START: begin
          pattern_out <= 1'b0;
          pat_ms <= '0;
          pat_ptr <= count - 1'b1;
          pat_left <= count;
          pat_st <= PAT_READ;
        end
        PAT_BLINK: begin
          if (count != 4'h0) begin
            pat_st <= PAT_START;
          end else if (tick) begin
            if (pat_ms == MS_W'(BLINK_MS - 1)) begin
              pat_ms <= '0;
              pattern_out <= ~pattern_out;
            end else begin
              pat_ms <= pat_ms + 1'b1;
            end
          end
        end
        PAT_READ: pat_st <= PAT_FETCH;
        PAT_FETCH: begin
          pulses <= q_b[7:4];
          ones <= q_b[3:0];
          second <= 1'b0;
          pat_ms <= '0;
          pattern_out <= 1'b1;
          pat_st <= PAT_DIGIT;
        end
        PAT_DIGIT: begin
          if (tick) begin
            if (pat_ms == MS_W'(BLINK_MS - 1)) begin
              pat_ms <= '0;
              if (pattern_out) begin
                pattern_out <= 1'b0;
                pulses <= pulses - 1'b1;
              end else if (pulses != 4'h0) begin
                pattern_out <= 1'b1;
              end else begin
                pat_st <= PAT_SPACE;
              end
            end else begin
              pat_ms <= pat_ms + 1'b1;
            end
          end
        end
        PAT_SPACE: begin
          if (tick) begin
            if (pat_ms == MS_W'((second ? CODE_GAP_MS : DIGIT_GAP_MS) - BLINK_MS - 1)) begin
              pat_ms <= '0;
              if (!second) begin
                second <= 1'b1;
                pulses <= ones;
                pattern_out <= 1'b1;
                pat_st <= PAT_DIGIT;
              end else if (pat_left > 4'h1) begin
                pat_left <= pat_left - 1'b1;
                pat_ptr <= pat_ptr - 1'b1;
                pat_st <= PAT_READ;
              end else begin
                pat_st <= PAT_START;
              end
            end else begin
              pat_ms <= pat_ms + 1'b1;
            end
          end
        end
        default: pat_st <= PAT_START;
      endcase
    end
  end
endmodule // fms_monitor
`default_nettype wire

// file: rtl/fms_ms_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fms_ms_timer import fms_pkg::*; (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic run,
  input wire logic [MS_W-1:0] limit,
  output logic done
);
  logic [MS_W-1:0] cnt;

  // counts ticks while run is high, clears as soon as run drops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      done <= 1'b0;
    end else if (!run) begin
      cnt <= '0;
      done <= 1'b0;
    end else if (tick && !done) begin
      if (cnt == limit - MS_W'(1)) done <= 1'b1;
      cnt <= cnt + 1'b1;
    end
  end
endmodule // fms_ms_timer
`default_nettype wire
